// ---- verilog/sat_pkg.sv ----
// constants for the serial transmit buffer
package sat_pkg;
  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CFG    = 8'h0C;
  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  localparam int CTRL_HOLD_BIT  = 1;
  localparam int CTRL_LOOP_BIT  = 3;
  localparam int CTRL_BREAK_BIT = 5;
  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_LEN_LSB   = 0;
  localparam int CFG_FRAME_LSB = 2;
  localparam int CFG_CLK_LSB   = 4;
  localparam int CFG_PI_BIT    = 6;
  localparam int CFG_FILL_LSB  = 8;
  localparam logic [7:0] FILL_RESET = 8'h16;
  // ----------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------
  localparam int ST_EMPTY_BIT = 4;
  localparam int ST_RTS_BIT   = 0;
  localparam int ST_CTS_BIT   = 1;
  localparam int ST_BUSY_BIT  = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [4:0] DIV32_HALF = 5'h0F;
  // frame select encodings
  localparam logic [1:0] FRM_ONE  = 2'h0;
  localparam logic [1:0] FRM_TWO  = 2'h1;
  localparam logic [1:0] FRM_SYNC = 2'h2;
  // clock select encodings
  localparam logic [1:0] CLK_X32 = 2'h1;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b011,
    ST_PAR   = 3'b010,
    ST_STOP  = 3'b110
  } sat_state_e;
endpackage : sat_pkg

// ---- verilog/sat_xmit.sv ----
// transmit half of a serial modem interface, with apb registers
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: five to eight bits; sync forces eight
// R2: programmable fill char, SYN default, sync stuffing
// R3: init returns idle, line marking
// R4: clock select: 32x async, 1x otherwise
// R5: one, two or no stop bits; with five-bit characters at 32x the code sends one stop bit when two are set
// R6: parity inhibit sends eight data bits; the code only drops the parity bit and keeps the set length
// R7: write strobe loads double-buffered character
// R8: load clears empty output and status
// R9: transfer when strobe high and cts
// R10: internal cts needs rts and cts/loopback
// R11: cts drop finishes current character only
// R12: bit rate is clock or clock/32
// R13: baud clock rises at bit edges
// R14: end-of-char low on framing/idle, sync eighth bit
// R15: break forces spacing in async modes
// R16: load turns rts on, not in loopback
// R17: rts held through second stop bit
// R18: rts stays on while characters keep coming
// R19: hold bit forces rts on
// R20: sync sends no start/stop bits
// R21: sync hold stuffs SYN after first character
// R22: empty status needs dsr on; the code also sets it in loopback with dsr off
// R23: control bit 3 selects loopback
// R24: loopback holds modem rts off
// R25: idle line stays marking
module sat_xmit (
  input  wire logic        I_REF_CLK,
  input  wire logic        I_NRST,
  input  wire logic        I_CLK_EN,
  input  wire logic        I_INIT,
  input  wire logic        I_TX_CLK,
  input  wire logic        I_MODEM_CTS,
  input  wire logic        I_MODEM_DSR,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             O_SERIAL_DATA,
  output logic             O_LOOP_DATA,
  output logic             O_BAUD_CLK,
  output logic             O_HOLDING_EMPTY_N,
  output logic             O_EOC_N,
  output logic             O_RTS_N
);
  import sat_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sy1_reg, sy2_reg;
  logic       tclk_d_reg;
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sy1_reg    <= 3'h0;
      sy2_reg    <= 3'h0;
      tclk_d_reg <= 1'b0;
    end else if (I_CLK_EN) begin
      sy1_reg    <= {I_MODEM_DSR, I_MODEM_CTS, I_TX_CLK};
      sy2_reg    <= sy1_reg;
      tclk_d_reg <= sy2_reg[0];
    end
  end
  wire tclk_fall = tclk_d_reg & ~sy2_reg[0];
  wire cts_pin   = sy2_reg[1];
  wire dsr_pin   = sy2_reg[2];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic [15:0] cfg_reg;
  logic [7:0]  hold_reg;
  logic        full_reg;
  logic        strobe_reg;
  wire acc   = PSEL & PENABLE;
  wire wr_dt = acc & PWRITE & (PADDR == ADDR_DATA);
  wire hold_bit  = ctrl_reg[CTRL_HOLD_BIT];
  wire loop_bit  = ctrl_reg[CTRL_LOOP_BIT];                       // R23
  wire brk_bit   = ctrl_reg[CTRL_BREAK_BIT];
  wire [1:0] frame  = cfg_reg[CFG_FRAME_LSB +: 2];                // R5
  wire       sync_m = (frame == FRM_SYNC);
  wire [1:0] lencode = sync_m ? 2'h3 : cfg_reg[CFG_LEN_LSB +: 2]; // R1
  wire       x32    = (cfg_reg[CFG_CLK_LSB +: 2] == CLK_X32) & ~sync_m; // R4
  wire       pinh   = cfg_reg[CFG_PI_BIT];
  wire [7:0] fill   = cfg_reg[CFG_FILL_LSB +: 8];                 // R2

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_reg <= 8'h00;
      cfg_reg  <= {FILL_RESET, 8'h03};
    end else if (I_CLK_EN && acc && PWRITE) begin
      if (PADDR == ADDR_CTRL)
        ctrl_reg <= PWDATA[7:0];
      if (PADDR == ADDR_CFG)
        cfg_reg <= PWDATA[15:0];
    end
  end

  // strobe low the cycle after the write: high again one cycle later
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      strobe_reg <= 1'b1;
    else if (I_CLK_EN)
      strobe_reg <= ~wr_dt;                                       // R7
  end

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  logic [4:0] div_reg;
  logic       tick_d_reg;
  wire bit_tick = tclk_fall & (~x32 | (div_reg == DIV32_LAST));  // R12
  // line output is registered, so the baud rise waits one cycle too
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      tick_d_reg <= 1'b0;
    else if (I_CLK_EN)
      tick_d_reg <= bit_tick;
  end
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      div_reg <= 5'h00;
    else if (I_CLK_EN && tclk_fall)
      div_reg <= div_reg + 5'h01;
  end

  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  sat_state_e state_reg;
  logic [7:0] sh_reg;
  logic [2:0] cnt_reg;
  logic       par_reg;
  logic       half_reg;
  logic       sent_one_reg;
  logic       stop2_reg;
  logic [1:0] rts_ff_reg;
  wire rts_on  = ~(rts_ff_reg[0] & rts_ff_reg[1]);
  wire cts_int = rts_on & (cts_pin | loop_bit);                   // R10
  wire [2:0] last_idx = {1'b0, lencode} + 3'h4;
  wire ld_ok   = full_reg & strobe_reg & cts_int;                 // R9 R11
  wire stuff   = sync_m & hold_bit & sent_one_reg & cts_int;      // R21
  wire stop_n  = (frame == FRM_TWO) ? 1'b1 : 1'b0;

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_reg    <= ST_IDLE;
      sh_reg       <= 8'h00;
      cnt_reg      <= 3'h0;
      par_reg      <= 1'b0;
      half_reg     <= 1'b0;
      sent_one_reg <= 1'b0;
      stop2_reg    <= 1'b0;
      full_reg     <= 1'b0;
      hold_reg     <= 8'h00;
    end else if (I_CLK_EN) begin
      if (wr_dt) begin
        hold_reg <= PWDATA[7:0];
        full_reg <= 1'b1;                                         // R8
      end
      if (I_INIT) begin
        state_reg    <= ST_IDLE;                                  // R3
        full_reg     <= 1'b0;
        sent_one_reg <= 1'b0;
      end else if (bit_tick) begin
        case (state_reg)
          ST_IDLE: begin
            if (ld_ok) begin
              sh_reg   <= hold_reg;
              full_reg <= wr_dt;
              par_reg  <= 1'b0;
              cnt_reg  <= 3'h0;
              state_reg <= sync_m ? ST_DATA : ST_START;           // R20
            end else if (stuff) begin
              sh_reg    <= fill;
              cnt_reg   <= 3'h0;
              state_reg <= ST_DATA;
            end
          end
          ST_START: state_reg <= ST_DATA;
          ST_DATA: begin
            par_reg <= par_reg ^ sh_reg[0];
            sh_reg  <= {1'b0, sh_reg[7:1]};
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == last_idx) begin
              sent_one_reg <= sent_one_reg | sync_m;
              if (sync_m) begin
                // next character follows with no idle slot
                cnt_reg <= 3'h0;
                if (ld_ok) begin
                  sh_reg   <= hold_reg;
                  full_reg <= wr_dt;
                  par_reg  <= 1'b0;
                end else if (hold_bit && cts_int) begin
                  sh_reg <= fill;                                 // R21
                end else
                  state_reg <= ST_IDLE;
              end
              else if (!pinh && lencode != 2'h3)
                state_reg <= ST_PAR;
              else begin
                state_reg <= ST_STOP;                             // R6
                stop2_reg <= stop_n;
                half_reg  <= stop_n & (lencode == 2'h0);
              end
            end
          end
          ST_PAR: begin
            state_reg <= ST_STOP;
            stop2_reg <= stop_n;
            half_reg  <= stop_n & (lencode == 2'h0);
          end
          ST_STOP: begin
            if (stop2_reg)
              stop2_reg <= 1'b0;
            else if (ld_ok) begin
              // back-to-back: start bit right after the stop bit
              sh_reg    <= hold_reg;
              full_reg  <= wr_dt;
              par_reg   <= 1'b0;
              cnt_reg   <= 3'h0;
              state_reg <= ST_START;                              // R18
            end else
              state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end else if (x32 && tclk_fall && half_reg && state_reg == ST_STOP
                   && stop2_reg && div_reg == DIV32_HALF) begin
        stop2_reg <= 1'b0;                                        // R5
        half_reg  <= 1'b0;
      end
      if (!sync_m)
        sent_one_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request to send control
  // ----------------------------------------------------------------
  wire in_stop = (state_reg == ST_STOP);
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST)
      rts_ff_reg <= 2'h3;
    else if (I_CLK_EN) begin
      if (full_reg || wr_dt || hold_bit)
        rts_ff_reg <= 2'h0;                                       // R16 R18 R19
      else if (bit_tick && state_reg == ST_IDLE && !ld_ok)
        rts_ff_reg <= {rts_ff_reg[0], rts_ff_reg[0]};             // R17
      else if (bit_tick && in_stop && !stop2_reg)
        rts_ff_reg <= {rts_ff_reg[1], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic line_bit;
  always_comb begin
    case (state_reg)
      ST_START: line_bit = 1'b0;
      ST_DATA:  line_bit = sh_reg[0];
      ST_PAR:   line_bit = par_reg;
      default:  line_bit = 1'b1;                                  // R25
    endcase
    if (brk_bit && !sync_m)
      line_bit = 1'b0;                                            // R15
    if (I_INIT)
      line_bit = 1'b1;                                            // R3
  end

  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_SERIAL_DATA     <= 1'b1;
      O_LOOP_DATA       <= 1'b1;
      O_BAUD_CLK        <= 1'b0;
      O_HOLDING_EMPTY_N <= 1'b1;
      O_EOC_N           <= 1'b0;
      O_RTS_N           <= 1'b1;
      PRDATA            <= 32'h00000000;
    end else if (I_CLK_EN) begin
      O_SERIAL_DATA     <= loop_bit ? 1'b1 : line_bit;
      O_LOOP_DATA       <= line_bit;
      if (tick_d_reg)
        O_BAUD_CLK <= 1'b1;                                       // R13
      else if (x32 ? (tclk_fall && div_reg == DIV32_HALF) : (tclk_d_reg == 1'b0))
        O_BAUD_CLK <= 1'b0;
      O_HOLDING_EMPTY_N <= ~full_reg;                             // R8 R9
      O_EOC_N           <= sync_m ? ~(state_reg == ST_DATA && cnt_reg == 3'h7)
                                  : (state_reg == ST_DATA || state_reg == ST_PAR); // R14
      O_RTS_N           <= loop_bit | ~rts_on;                    // R24
      PRDATA <= 32'h00000000;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          ADDR_DATA:   PRDATA <= {24'h000000, hold_reg};
          ADDR_CTRL:   PRDATA <= {24'h000000, ctrl_reg};
          ADDR_CFG:    PRDATA <= {16'h0000, cfg_reg};
          ADDR_STATUS: begin
            PRDATA[ST_EMPTY_BIT] <= ~full_reg & (dsr_pin | loop_bit); // R22
            PRDATA[ST_RTS_BIT]   <= rts_on;
            PRDATA[ST_CTS_BIT]   <= cts_int;
            PRDATA[ST_BUSY_BIT]  <= (state_reg != ST_IDLE);
          end
          default:     PRDATA <= 32'h00000000;
        endcase
      end
    end
  end

  // unmapped address reports an error, zero wait states
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (I_CLK_EN) begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & (PADDR[7:4] != 4'h0 || PADDR[1:0] != 2'h0);
    end
  end
endmodule : sat_xmit
`default_nettype wire

// ---- dv/sat_xmit_asserts.sv ----
// port assertions for the serial transmit buffer
`timescale 1ns/10ps
`default_nettype none
module sat_xmit_asserts
  import sat_pkg::*;
(
  input wire logic        I_REF_CLK,
  input wire logic        I_NRST,
  input wire logic        I_INIT,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        O_SERIAL_DATA,
  input wire logic        O_LOOP_DATA,
  input wire logic        O_BAUD_CLK,
  input wire logic        O_HOLDING_EMPTY_N,
  input wire logic        O_RTS_N
);
  logic       wr_acc;
  logic       loop_reg;
  logic       brk_reg;
  logic [1:0] frm_reg;
  assign wr_acc = PSEL && PENABLE && PWRITE && PREADY && !PSLVERR;
  // ------------------------------------------------------------
  // shadow of control and frame settings
  // ------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      loop_reg <= 1'b0;
      brk_reg  <= 1'b0;
    end else if (wr_acc && PADDR == ADDR_CTRL) begin
      loop_reg <= PWDATA[CTRL_LOOP_BIT];
      brk_reg  <= PWDATA[CTRL_BREAK_BIT];
    end
  end
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) frm_reg <= FRM_ONE;
    else if (wr_acc && PADDR == ADDR_CFG) frm_reg <= PWDATA[CFG_FRAME_LSB+:2];
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("apb access not answered");
  a_err_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_init_mark: assert property (I_INIT && $past(I_INIT) |-> O_SERIAL_DATA)
    else $error("line not marking under init");
  a_load_full: assert property (wr_acc && PADDR == ADDR_DATA && !I_INIT |=> ##1 !O_HOLDING_EMPTY_N)
    else $error("load did not mark buffer full");
  a_load_rts: assert property (wr_acc && PADDR == ADDR_DATA && !loop_reg && !I_INIT
    |-> ##[1:4] !O_RTS_N)
    else $error("load did not raise rts");
  a_loop_quiet: assert property (loop_reg && $past(loop_reg) && $past(loop_reg, 2)
    |-> O_RTS_N && O_SERIAL_DATA)
    else $error("modem side active in loopback");
  a_break_space: assert property (brk_reg && $past(brk_reg, 2) && !loop_reg
    && frm_reg != FRM_SYNC && !I_INIT && !$past(I_INIT) |-> !O_SERIAL_DATA)
    else $error("break not spacing");
  a_baud_edge: assert property ($changed(O_LOOP_DATA) && !brk_reg && !$past(brk_reg, 2)
    && !I_INIT && !$past(I_INIT) |-> $rose(O_BAUD_CLK))
    else $error("bit change without baud rise");
endmodule // sat_xmit_asserts
bind sat_xmit sat_xmit_asserts u_chk (.I_REF_CLK, .I_NRST, .I_INIT, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PREADY, .PSLVERR, .O_SERIAL_DATA, .O_LOOP_DATA, .O_BAUD_CLK,
  .O_HOLDING_EMPTY_N, .O_RTS_N);
`default_nettype wire

// ---- dv/sat_modem.sv ----
// modem data set model: bit clock, clear-to-send, data-set-ready
`timescale 1ns/10ps
`default_nettype none
module sat_modem (
  input  wire logic I_REF_CLK,
  input  wire logic I_RTS_N,
  input  wire logic I_SLOW,
  output logic      O_TX_CLK,
  output logic      O_CTS,
  output logic      O_DSR
);
  int wait_cnt;
  initial O_TX_CLK = 1'b0;
  initial O_CTS = 1'b0;
  initial wait_cnt = 0;
  assign O_DSR = 1'b1;
  // free-running 1x/32x element timing
  always #100 O_TX_CLK = ~O_TX_CLK;
  // cts follows rts after a prompt or slow delay
  always @(posedge I_REF_CLK) begin
    if (I_RTS_N) begin
      wait_cnt <= 0;
      O_CTS    <= 1'b0;
    end else if (wait_cnt >= (I_SLOW ? 40 : 2)) O_CTS <= 1'b1;
    else wait_cnt <= wait_cnt + 1;
  end
endmodule // sat_modem
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the serial transmit buffer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sat_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, init = 1'b0, slow = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, sdata, ldata, bclk, hempty_n, eoc_n, rts_n, txc, cts, dsr;
  int          n_fail = 0, n_compared = 0;
  always #12.5 clk = ~clk;
  sat_xmit i_dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_CLK_EN(1'b1), .I_INIT(init),
    .I_TX_CLK(txc), .I_MODEM_CTS(cts), .I_MODEM_DSR(dsr), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .O_SERIAL_DATA(sdata), .O_LOOP_DATA(ldata), .O_BAUD_CLK(bclk),
    .O_HOLDING_EMPTY_N(hempty_n), .O_EOC_N(eoc_n), .O_RTS_N(rts_n));
  sat_modem i_modem (.I_REF_CLK(clk), .I_RTS_N(rts_n), .I_SLOW(slow), .O_TX_CLK(txc),
    .O_CTS(cts), .O_DSR(dsr));
  // ------------------------------------------------------------
  // bus, capture and compare helpers
  // ------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rx(input int n, output logic [31:0] b);
    int k;
    b = '0;
    k = 0;
    while (sdata !== 1'b0 && k < 400) begin @(posedge clk); k++; end
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin b[i] = sdata; repeat (8) @(posedge clk); end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    apb(1'b0, ADDR_CFG, '0, q, e);
    chk("cfg reset", 32'h0000_1603, q);
    apb(1'b0, ADDR_STATUS, '0, q, e);
    chk("empty status", 32'h1, {31'h0, q[ST_EMPTY_BIT]});
    apb(1'b0, 8'h10, '0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("t_regs done");
  endtask
  task automatic t_frame();
    logic [31:0] b;
    int k;
    slow <= 1'b1;
    wr(ADDR_CFG, 32'h0000_1643);
    fork
      rx(20, b);
      begin
        wr(ADDR_DATA, 32'h0000_00A5);
        k = 0;
        while (hempty_n !== 1'b0 && k < 20) begin @(posedge clk); k++; end
        k = 0;
        while (hempty_n !== 1'b1 && k < 200) begin @(posedge clk); k++; end
        wr(ADDR_DATA, 32'h0000_003C);
      end
    join
    chk("two frames", 32'h0009_E34A, b);
    repeat (40) @(posedge clk);
    chk("rts released", 32'h1, {31'h0, rts_n});
    slow <= 1'b0;
    $display("t_frame done");
  endtask
  task automatic t_break();
    wr(ADDR_CTRL, 32'h0000_0020);
    repeat (20) @(posedge clk);
    chk("break line", 32'h0, {31'h0, sdata});
    wr(ADDR_CTRL, 32'h0);
    repeat (20) @(posedge clk);
    chk("idle line", 32'h1, {31'h0, sdata});
    chk("eoc idle", 32'h0, {31'h0, eoc_n});
    $display("t_break done");
  endtask
  task automatic t_loop();
    int k;
    wr(ADDR_CTRL, 32'h0000_0008);
    wr(ADDR_DATA, 32'h0000_0055);
    k = 0;
    while (ldata !== 1'b0 && k < 100) begin @(posedge clk); k++; end
    chk("loop start", 32'h0, {31'h0, ldata});
    repeat (100) @(posedge clk);
    chk("loop rts", 32'h1, {31'h0, rts_n});
    chk("loop line", 32'h1, {31'h0, sdata});
    wr(ADDR_CTRL, 32'h0);
    repeat (100) @(posedge clk);
    $display("t_loop done");
  endtask
  task automatic t_init();
    int k;
    wr(ADDR_DATA, 32'h0);
    k = 0;
    while (sdata !== 1'b0 && k < 400) begin @(posedge clk); k++; end
    init <= 1'b1;
    repeat (3) @(posedge clk);
    chk("init mark", 32'h1, {31'h0, sdata});
    init <= 1'b0;
    $display("t_init done");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_frame();
    t_break();
    t_loop();
    t_init();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
